// ---- src/gweaa_regs.vh ----
// Constants for the grouped word error correction array access block
`ifndef GWEAA_REGS_VH
`define GWEAA_REGS_VH
`define GWEAA_ADDR_W       16
`define GWEAA_DATA_W       32
`define GWEAA_CHK_W        7
`define GWEAA_CW_W         39
`define GWEAA_PAGE_BYTES   128
`define GWEAA_TWC_MS       5
`define GWEAA_CLK_KHZ      100000
`define GWEAA_TWC_CYCLES   (`GWEAA_TWC_MS * `GWEAA_CLK_KHZ)
`define GWEAA_STATUS_BUSY  8'hff
`endif

// ---- src/gweaa_hamming.v ----
// Single-error-correcting code over one 32-bit group, encode and correct
`timescale 1ns/10ps
`default_nettype none
`include "gweaa_regs.vh"
module gweaa_hamming (
  // Data to encode
  input  wire [31:0] enc_data,
  output reg  [6:0]  enc_chk,
  // Stored word to correct
  input  wire [31:0] dec_data,
  input  wire [6:0]  dec_chk,
  output reg  [31:0] dec_fixed,
  output reg         dec_single,
  output reg         dec_double
);
  // Data bit i sits at code position pos(i), skipping powers of two
  function [5:0] pos;
    input integer i;
    integer p;
    integer n;
    begin
      p = 1;
      n = -1;
      pos = 6'h00;
      while (n < i) begin
        p = p + 1;
        if ((p & (p - 1)) != 0) begin
          n = n + 1;
        end
      end
      pos = p[5:0];
    end
  endfunction

  integer i;
  integer j;
  reg [5:0] syn;
  reg       par;
  always @* begin
    enc_chk = 7'h00;
    for (i = 0; i < 32; i = i + 1) begin
      if (enc_data[i]) begin
        enc_chk[5:0] = enc_chk[5:0] ^ pos(i);
      end
    end
    enc_chk[6] = ^{enc_data, enc_chk[5:0]};
  end

  always @* begin
    syn = dec_chk[5:0];
    for (j = 0; j < 32; j = j + 1) begin
      if (dec_data[j]) begin
        syn = syn ^ pos(j);
      end
    end
    par = ^{dec_data, dec_chk};
    dec_fixed = dec_data;
    for (j = 0; j < 32; j = j + 1) begin
      if (par && (syn == pos(j))) begin
        dec_fixed[j] = ~dec_data[j];
      end
    end
    dec_single = par;
    dec_double = (~par) && (syn != 6'h00);
  end
endmodule // gweaa_hamming
`default_nettype wire

// ---- src/gweaa_core.v ----
// Error corrected grouped array access between command decoder and array
// Behaviour
// - Check bits cover four-byte groups only
// - Group is bytes 4N to 4N+3
// - Single bad bit corrected on read
// - Single byte writes accepted
// - Byte write rewrites whole group, new check
// - No added opcodes, status or timing
// - Byte or page write starts write cycle
// - Write stays inside one 128-byte page
// - Busy: only status read, reads all ones
`timescale 1ns/10ps
`default_nettype none
`include "gweaa_regs.vh"
module gweaa_core #(
  parameter TWC_CYCLES = `GWEAA_TWC_CYCLES
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // Read request from command decoder
  input  wire        rd_req,
  input  wire [15:0] rd_addr,
  output reg         rd_valid,
  output reg  [7:0]  rd_data,
  // Write buffer load and commit from command decoder
  input  wire        wr_load,
  input  wire [15:0] wr_addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_commit,
  // Status read during write cycle
  input  wire        st_req,
  output reg         st_valid,
  output reg  [7:0]  st_data,
  // Array state
  output reg         busy,
  output reg         err_corrected
);
  localparam S_IDLE = 2'h0;
  localparam S_MERGE = 2'h1;
  localparam S_WAIT = 2'h2;

  // Array with seven check bits per group
  reg [31:0] mem_data [0:16383];
  reg [6:0]  mem_chk  [0:16383];

  // Page buffer: byte values and byte-written marks
  reg [7:0]  pg_byte [0:127];
  reg        pg_mark [0:127];
  reg [8:0]  pg_base_reg;
  reg        pg_any_reg;

  reg [1:0]  state_reg;
  reg [5:0]  grp_reg;
  reg [31:0] tmr_reg;

  wire [13:0] rd_grp = rd_addr[15:2];
  wire [13:0] mg_grp = {pg_base_reg, grp_reg[4:0]};
  wire [31:0] rd_word = mem_data[rd_grp];
  wire [6:0]  rd_chk = mem_chk[rd_grp];
  wire [31:0] mg_word = mem_data[mg_grp];
  wire [6:0]  mg_chk = mem_chk[mg_grp];
  wire [31:0] rd_fixed;
  wire [31:0] mg_fixed;
  wire        rd_single;
  wire [6:0]  new_chk;
  reg  [31:0] mg_new;
  integer     k;
  integer     m;

  gweaa_hamming u_rd (
    .enc_data   (32'h00000000),
    .enc_chk    (),
    .dec_data   (rd_word),
    .dec_chk    (rd_chk),
    .dec_fixed  (rd_fixed),
    .dec_single (rd_single),
    .dec_double ()
  );

  gweaa_hamming u_mg (
    .enc_data   (mg_new),
    .enc_chk    (new_chk),
    .dec_data   (mg_word),
    .dec_chk    (mg_chk),
    .dec_fixed  (mg_fixed),
    .dec_single (),
    .dec_double ()
  );

  // Unwritten bytes keep corrected old contents
  always @* begin
    mg_new = mg_fixed;
    for (k = 0; k < 4; k = k + 1) begin
      if (pg_mark[{grp_reg[4:0], k[1:0]}]) begin
        mg_new[k*8 +: 8] = pg_byte[{grp_reg[4:0], k[1:0]}];
      end
    end
  end

  wire grp_dirty = pg_mark[{grp_reg[4:0], 2'h0}] | pg_mark[{grp_reg[4:0], 2'h1}] |
                   pg_mark[{grp_reg[4:0], 2'h2}] | pg_mark[{grp_reg[4:0], 2'h3}];

  // Read path, refused while busy
  always @(posedge ref_clk) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      err_corrected <= 1'b0;
      st_valid <= 1'b0;
      st_data <= 8'h00;
    end else begin
      rd_valid <= rd_req && !busy;
      st_valid <= st_req;
      st_data <= busy ? `GWEAA_STATUS_BUSY : 8'h00;
      err_corrected <= 1'b0;
      if (rd_req && !busy) begin
        rd_data <= rd_fixed[rd_addr[1:0]*8 +: 8];
        err_corrected <= rd_single;
      end
    end
  end

  // Page buffer load, address wraps in page
  always @(posedge ref_clk) begin
    if (reset || (state_reg == S_WAIT && tmr_reg == 32'h00000000)) begin
      for (m = 0; m < 128; m = m + 1) begin
        pg_mark[m] <= 1'b0;
      end
      pg_any_reg <= 1'b0;
      pg_base_reg <= 9'h000;
    end else if (wr_load && state_reg == S_IDLE) begin
      if (!pg_any_reg) begin
        pg_base_reg <= wr_addr[15:7];
      end
      pg_byte[wr_addr[6:0]] <= wr_data;
      pg_mark[wr_addr[6:0]] <= 1'b1;
      pg_any_reg <= 1'b1;
    end
  end

  // Write cycle: merge every dirty group, then hold busy for the cycle time
  always @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= S_IDLE;
      grp_reg <= 6'h00;
      tmr_reg <= 32'h00000000;
      busy <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (wr_commit && pg_any_reg) begin
            state_reg <= S_MERGE;
            grp_reg <= 6'h00;
            busy <= 1'b1;
          end
        end
        S_MERGE: begin
          if (grp_dirty) begin
            mem_data[mg_grp] <= mg_new;
            mem_chk[mg_grp] <= new_chk;
          end
          if (grp_reg == 6'h1f) begin
            state_reg <= S_WAIT;
            tmr_reg <= TWC_CYCLES - 33;
          end else begin
            grp_reg <= grp_reg + 6'h01;
          end
        end
        S_WAIT: begin
          if (tmr_reg == 32'h00000000) begin
            state_reg <= S_IDLE;
            busy <= 1'b0;
          end else begin
            tmr_reg <= tmr_reg - 32'h00000001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // gweaa_core
`default_nettype wire

// ---- tb/gweaa_core_props.sv ----
// Checker on the array access ports
`timescale 1ns/10ps
`default_nettype none
module gweaa_core_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Requests
  input wire logic       rd_req,
  input wire logic       wr_load,
  input wire logic       wr_commit,
  input wire logic       st_req,
  // Answers
  input wire logic       rd_valid,
  input wire logic       st_valid,
  input wire logic [7:0] st_data,
  input wire logic       busy,
  input wire logic       err_corrected
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_load;
    wr_load && !busy ##2 wr_commit;
  endsequence
  AST_RD_ANS: assert property (rd_req && !busy |=> rd_valid)
    else $error("read unanswered");
  AST_RD_BUSY: assert property (rd_req && busy |=> !rd_valid)
    else $error("read taken while busy");
  AST_ST_BUSY: assert property (st_req && busy |=> st_valid && st_data == 8'hff)
    else $error("busy status not ones");
  AST_ST_IDLE: assert property (st_req && !busy |=> st_valid && st_data == 8'h00)
    else $error("idle status wrong");
  AST_WR_START: assert property (s_load |-> ##[1:2] busy)
    else $error("write cycle not started");
  AST_WR_HOLD: assert property ($rose(busy) |-> busy[*8])
    else $error("write cycle too short");
  AST_ERR_RD: assert property (err_corrected |-> rd_valid)
    else $error("correction flag outside read");
  AST_RD_SRC: assert property (rd_valid |-> $past(rd_req) && !$past(busy))
    else $error("spurious read answer");
endmodule // gweaa_core_props
`default_nettype wire

// ---- tb/gweaa_host.sv ----
// Command decoder model issuing array requests
`timescale 1ns/10ps
`default_nettype none
module gweaa_host (
  // Clock
  input wire logic         ref_clk,
  // Requests
  output var logic [3:0]   req,
  output var logic [15:0]  addr,
  output var logic [7:0]   data
);
  initial {req, addr, data} = '0;
  // One pulse per request, single bytes only
  task automatic go(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= k;
    addr <= a;
    data <= d;
    @(posedge ref_clk);
    req <= 4'h0;
    addr <= ~a;
    data <= ~d;
  endtask
endmodule // gweaa_host
`default_nettype wire

// ---- tb/tb_gweaa_core.sv ----
// Testbench for the array access block
`timescale 1ns/10ps
`default_nettype none
module tb_gweaa_core;
  logic ref_clk, reset, rd_valid, st_valid, busy, err_corrected;
  logic [7:0] rd_data, st_data, wd;
  logic [3:0] req;
  logic [15:0] addr;
  logic [8:0] pg;
  logic [7:0] mem [int];
  int mismatches = 0;
  int total_checks = 0;
  int n;
  gweaa_host host_i (.ref_clk(ref_clk), .req(req), .addr(addr), .data(wd));
  gweaa_core #(.TWC_CYCLES(40)) gweaa_core_i (
    .ref_clk(ref_clk), .reset(reset), .rd_req(req[3]), .rd_addr(addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .wr_load(req[2]), .wr_addr(addr),
    .wr_data(wd), .wr_commit(req[1]), .st_req(req[0]), .st_valid(st_valid),
    .st_data(st_data), .busy(busy), .err_corrected(err_corrected));
  task chk(input bit ok);
    total_checks++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED %0t compare mismatch", $time);
    end
  endtask
  task ld(input logic [15:0] a);
    logic [7:0] d;
    d = $urandom;
    host_i.go(4'h4, a, d);
    mem[{pg, a[6:0]}] = d;
  endtask
  task rd(input logic [15:0] a);
    host_i.go(4'h8, a, 8'h00);
    #1 chk(rd_valid === 1'b1 && rd_data === mem[a] && err_corrected === 1'b0);
  endtask
  task commit;
    host_i.go(4'h2, 16'h0000, 8'h00);
    host_i.go(4'h1, 16'h0000, 8'h00);
    #1 chk(st_valid === 1'b1 && st_data === 8'hff);
    host_i.go(4'h8, 16'h0100, 8'h00);
    #1 chk(rd_valid === 1'b0 && busy === 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk(n < 200);
    host_i.go(4'h1, 16'h0000, 8'h00);
    #1 chk(st_valid === 1'b1 && st_data === 8'h00);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #20000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    reset = 1'b1;
    pg = 9'h002;
    void'($urandom(32'ha01ae0f6));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) ld(16'h0100 + i);
    commit;
    for (int i = 0; i < 4; i++) rd(16'h0100 + i);
    ld(16'h0102);
    commit;
    for (int i = 0; i < 4; i++) rd(16'h0100 + i);
    ld(16'h017f);
    ld(16'h0180);
    commit;
    rd(16'h0100);
    rd(16'h017f);
    n = $urandom % 32;
    gweaa_core_i.mem_data[14'h0040] = gweaa_core_i.mem_data[14'h0040] ^ (32'h1 << n);
    host_i.go(4'h8, 16'h0100 + n / 8, 8'h00);
    #1 chk(rd_valid === 1'b1 && rd_data === mem[16'h0100 + n / 8] && err_corrected === 1'b1);
    tally_and_finish;
  end
endmodule // tb_gweaa_core
bind gweaa_core gweaa_core_props gweaa_core_props_i (.ref_clk, .reset, .rd_req, .wr_load,
  .wr_commit, .st_req, .rd_valid, .st_valid, .st_data, .busy, .err_corrected);
`default_nettype wire
